// ===== hdl/bus_wake_timer_control_regs.sv
// Bus transceiver, wake source and periodic timer control registers
`timescale 1ns/1ps
`include "sbc_ctrl_params.svh"

module bus_wake_timer_control_regs
  import ctrl_bank_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire clk_sys,
  input wire reset,
  input wire soft_reset,
  input wire restart,
  input power_mode_e power_mode,
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  input wire wake_pin,
  output logic [1:0] can_mode,
  output logic [1:0] lin_ch_a_mode,
  output logic [1:0] lin_ch_b_mode,
  output logic [1:0] lin_ch_c_mode,
  output logic lin_slope_control_enable,
  output logic lin_low_slope_select,
  output logic lin_tx_timeout_enable,
  output logic stop_watchdog_disable,
  output logic wake_pin_pull_up,
  output logic wake_pin_pull_down,
  output logic wake_pin_wake,
  output logic timer_wake
);

  // ==========================================================
  // Helpers
  function automatic logic [1:0] effective_mode(input logic [1:0] stored,
                                                input logic low_power);
    if (low_power && stored == `MODE_NORMAL) begin
      effective_mode = `MODE_WAKE;
    end else begin
      effective_mode = stored;
    end
  endfunction

  function automatic logic [10:0] period_ms(input logic [2:0] code);
    case (code)
      3'h0: period_ms = `TMR_P0_MS;
      3'h1: period_ms = `TMR_P1_MS;
      3'h2: period_ms = `TMR_P2_MS;
      3'h3: period_ms = `TMR_P3_MS;
      3'h4: period_ms = `TMR_P4_MS;
      3'h5: period_ms = `TMR_P5_MS;
      3'h6: period_ms = `TMR_P6_MS;
      default: period_ms = `TMR_OFF_MS;
    endcase
  endfunction

  // ==========================================================
  // Register storage
  logic [7:0] bus_control_first;
  logic [7:0] bus_control_second;
  logic [7:0] wake_control_first;
  logic [7:0] wake_source_control;
  logic [7:0] wake_pin_level_control;
  logic [7:0] periodic_timer_control;
  logic [7:0] next_bus_control_first;
  logic [7:0] next_bus_control_second;
  logic [7:0] next_wake_control_first;
  logic [7:0] next_wake_source_control;
  logic [7:0] next_wake_pin_level_control;
  logic [7:0] next_periodic_timer_control;
  logic [7:0] next_reg_rd_data;

  always_comb begin
    next_bus_control_first = bus_control_first;
    next_bus_control_second = bus_control_second;
    next_wake_control_first = wake_control_first;
    next_wake_source_control = wake_source_control;
    next_wake_pin_level_control = wake_pin_level_control;
    next_periodic_timer_control = periodic_timer_control;
    if (soft_reset) begin
      next_bus_control_first = `RST_BUS_CTRL_A;
      next_bus_control_second = `RST_BUS_CTRL_B;
      next_wake_control_first = `RST_WAKE_CTRL_A;
      next_wake_source_control = `RST_WAKE_SRC;
      next_wake_pin_level_control = `RST_WAKE_PULL;
      next_periodic_timer_control = `RST_TIMER_CTRL;
    end else if (restart) begin
      next_bus_control_first = bus_control_first & `KEEP_BUS_CTRL_A;
      next_bus_control_second = bus_control_second & `KEEP_BUS_CTRL_B;
      next_wake_control_first = wake_control_first & `KEEP_WAKE_CTRL_A;
      next_wake_source_control = wake_source_control & `KEEP_WAKE_SRC;
      next_wake_pin_level_control =
        wake_pin_level_control & `KEEP_WAKE_PULL;
      next_periodic_timer_control =
        periodic_timer_control & `KEEP_TIMER_CTRL;
    end else if (reg_wr) begin
      // Reserved bits are masked out on every write
      case (reg_addr)
        `OFS_BUS_CTRL_A: begin
          next_bus_control_first = reg_wr_data & `WM_BUS_CTRL_A;
        end
        `OFS_BUS_CTRL_B: begin
          next_bus_control_second = reg_wr_data & `WM_BUS_CTRL_B;
        end
        `OFS_WAKE_CTRL_A: begin
          next_wake_control_first = reg_wr_data & `WM_WAKE_CTRL_A;
        end
        `OFS_WAKE_SRC: begin
          next_wake_source_control = reg_wr_data & `WM_WAKE_SRC;
        end
        `OFS_WAKE_PULL: begin
          next_wake_pin_level_control =
            reg_wr_data & `WM_WAKE_PULL;
        end
        `OFS_TIMER_CTRL: begin
          next_periodic_timer_control =
            reg_wr_data & `WM_TIMER_CTRL;
        end
        default: begin
        end
      endcase
    end
  end

  // Read data follows the address one cycle later
  always_comb begin
    case (reg_addr)
      `OFS_BUS_CTRL_A: next_reg_rd_data = bus_control_first;
      `OFS_BUS_CTRL_B: next_reg_rd_data = bus_control_second;
      `OFS_WAKE_CTRL_A: next_reg_rd_data = wake_control_first;
      `OFS_WAKE_SRC: next_reg_rd_data = wake_source_control;
      `OFS_WAKE_PULL: next_reg_rd_data = wake_pin_level_control;
      `OFS_TIMER_CTRL: next_reg_rd_data = periodic_timer_control;
      default: next_reg_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bus_control_first <= `RST_BUS_CTRL_A;
      bus_control_second <= `RST_BUS_CTRL_B;
      wake_control_first <= `RST_WAKE_CTRL_A;
      wake_source_control <= `RST_WAKE_SRC;
      wake_pin_level_control <= `RST_WAKE_PULL;
      periodic_timer_control <= `RST_TIMER_CTRL;
      reg_rd_data <= 8'h00;
    end else begin
      bus_control_first <= next_bus_control_first;
      bus_control_second <= next_bus_control_second;
      wake_control_first <= next_wake_control_first;
      wake_source_control <= next_wake_source_control;
      wake_pin_level_control <= next_wake_pin_level_control;
      periodic_timer_control <= next_periodic_timer_control;
      reg_rd_data <= next_reg_rd_data;
    end
  end

  // ==========================================================
  // Wake pin synchroniser and wake detection
  logic wake_pin_meta;
  logic wake_pin_sync;
  logic wake_pin_prev;
  logic low_power;
  logic next_wake_pin_wake;
  logic next_pull_up;
  logic next_pull_down;

  assign low_power = (power_mode == pm_stop) || (power_mode == pm_sleep);

  always_comb begin
    next_wake_pin_wake = low_power &&
      wake_source_control[`BIT_WAKE_PIN_EN] &&
      (wake_pin_sync != wake_pin_prev);
    case (wake_pin_level_control[`FLD_LO_MSB:`FLD_LO_LSB])
      `PULL_DOWN: begin
        next_pull_up = 1'b0;
        next_pull_down = 1'b1;
      end
      `PULL_UP: begin
        next_pull_up = 1'b1;
        next_pull_down = 1'b0;
      end
      `PULL_AUTO: begin
        // Pull toward the level the pin currently holds
        next_pull_up = wake_pin_sync;
        next_pull_down = !wake_pin_sync;
      end
      default: begin
        next_pull_up = 1'b0;
        next_pull_down = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wake_pin_meta <= 1'b0;
      wake_pin_sync <= 1'b0;
      wake_pin_prev <= 1'b0;
      wake_pin_wake <= 1'b0;
      wake_pin_pull_up <= 1'b0;
      wake_pin_pull_down <= 1'b0;
    end else begin
      wake_pin_meta <= wake_pin;
      wake_pin_sync <= wake_pin_meta;
      wake_pin_prev <= wake_pin_sync;
      wake_pin_wake <= next_wake_pin_wake;
      wake_pin_pull_up <= next_pull_up;
      wake_pin_pull_down <= next_pull_down;
    end
  end

  // ==========================================================
  // Periodic timer: millisecond prescaler and period counter
  timer_state_e timer_state;
  timer_state_e next_timer_state;
  logic [31:0] prescale;
  logic [31:0] next_prescale;
  logic [10:0] ms_count;
  logic [10:0] next_ms_count;
  logic [10:0] limit_ms;
  logic timer_armed;
  logic ms_tick;
  logic next_timer_wake;

  assign limit_ms =
    period_ms(periodic_timer_control[`FLD_TMR_MSB:`FLD_LO_LSB]);
  assign timer_armed = low_power &&
    wake_control_first[`BIT_TMR_WAKE_EN] &&
    (limit_ms != `TMR_OFF_MS);
  assign ms_tick = (prescale == 32'(TICK_CYCLES - 1));

  always_comb begin
    next_timer_state = timer_state;
    next_prescale = prescale;
    next_ms_count = ms_count;
    next_timer_wake = 1'b0;
    case (timer_state)
      tm_idle: begin
        next_prescale = 32'h0;
        next_ms_count = 11'h0;
        if (timer_armed) begin
          next_timer_state = tm_run;
        end
      end
      tm_run: begin
        // Any register write or a disarm restarts the count
        if (!timer_armed || reg_wr) begin
          next_timer_state = tm_idle;
        end else if (ms_tick) begin
          next_prescale = 32'h0;
          if (ms_count == limit_ms - 11'h1) begin
            next_ms_count = 11'h0;
            next_timer_wake = 1'b1;
          end else begin
            next_ms_count = ms_count + 11'h1;
          end
        end else begin
          next_prescale = prescale + 32'h1;
        end
      end
      default: begin
        next_timer_state = tm_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      timer_state <= tm_idle;
      prescale <= 32'h0;
      ms_count <= 11'h0;
      timer_wake <= 1'b0;
    end else begin
      timer_state <= next_timer_state;
      prescale <= next_prescale;
      ms_count <= next_ms_count;
      timer_wake <= next_timer_wake;
    end
  end

  // ==========================================================
  // Transceiver controls with low-power override
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      can_mode <= 2'h0;
      lin_ch_a_mode <= 2'h0;
      lin_ch_b_mode <= 2'h0;
      lin_ch_c_mode <= 2'h0;
      lin_slope_control_enable <= 1'b1;
      lin_low_slope_select <= 1'b0;
      lin_tx_timeout_enable <= 1'b0;
      stop_watchdog_disable <= 1'b0;
    end else begin
      can_mode <= effective_mode(
        bus_control_first[`FLD_LO_MSB:`FLD_LO_LSB],
        low_power);
      lin_ch_a_mode <= effective_mode(
        bus_control_first[`FLD_HI_MSB:`FLD_HI_LSB],
        low_power);
      lin_ch_b_mode <= effective_mode(
        bus_control_second[`FLD_LO_MSB:`FLD_LO_LSB],
        low_power);
      lin_ch_c_mode <= effective_mode(
        bus_control_second[`FLD_HI_MSB:`FLD_HI_LSB],
        low_power);
      lin_slope_control_enable <=
        !bus_control_first[`BIT_LIN_FLASH];
      lin_low_slope_select <= bus_control_first[`BIT_LOW_SLOPE];
      lin_tx_timeout_enable <= bus_control_first[`BIT_LIN_TXTO];
      stop_watchdog_disable <= (power_mode == pm_stop) &&
        wake_control_first[`BIT_STOP_WD_OFF];
    end
  end

endmodule

// ===== hdl/sbc_ctrl_params.svh
// Constants for the bus, wake and periodic timer control registers
`ifndef CTRL_BANK_PARAMS_SVH
`define CTRL_BANK_PARAMS_SVH

// ==========================================================
// Register offsets (7-bit register address)
`define OFS_BUS_CTRL_A 7'h04
`define OFS_BUS_CTRL_B 7'h05
`define OFS_WAKE_CTRL_A 7'h06
`define OFS_WAKE_SRC 7'h07
`define OFS_WAKE_PULL 7'h08
`define OFS_TIMER_CTRL 7'h0c

// ==========================================================
// Power-on / soft reset values
`define RST_BUS_CTRL_A 8'h20
`define RST_BUS_CTRL_B 8'h00
`define RST_WAKE_CTRL_A 8'h00
`define RST_WAKE_SRC 8'h01
`define RST_WAKE_PULL 8'h00
`define RST_TIMER_CTRL 8'h00

// ==========================================================
// Writable bits; all others are reserved and read zero
`define WM_BUS_CTRL_A 8'hfb
`define WM_BUS_CTRL_B 8'h1b
`define WM_WAKE_CTRL_A 8'h44
`define WM_WAKE_SRC 8'h01
`define WM_WAKE_PULL 8'h03
`define WM_TIMER_CTRL 8'h07

// ==========================================================
// Bits kept across a device restart
`define KEEP_BUS_CTRL_A 8'hfb
`define KEEP_BUS_CTRL_B 8'h1b
`define KEEP_WAKE_CTRL_A 8'h40
`define KEEP_WAKE_SRC 8'h01
`define KEEP_WAKE_PULL 8'h03
`define KEEP_TIMER_CTRL 8'h07

// ==========================================================
// Field positions
`define BIT_LIN_FLASH 7
`define BIT_LOW_SLOPE 6
`define BIT_LIN_TXTO 5
`define FLD_HI_MSB 4
`define FLD_HI_LSB 3
`define FLD_LO_MSB 1
`define FLD_LO_LSB 0
`define BIT_TMR_WAKE_EN 6
`define BIT_STOP_WD_OFF 2
`define BIT_WAKE_PIN_EN 0
`define FLD_TMR_MSB 2

// ==========================================================
// Mode codes
`define MODE_WAKE 2'h1
`define MODE_NORMAL 2'h3
`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2
`define PULL_AUTO 2'h3

// ==========================================================
// Timing
`define CLK_PERIOD_NS 10
`define TICK_NS 1000000
`define TMR_P0_MS 11'h00a
`define TMR_P1_MS 11'h014
`define TMR_P2_MS 11'h032
`define TMR_P3_MS 11'h064
`define TMR_P4_MS 11'h0c8
`define TMR_P5_MS 11'h3e8
`define TMR_P6_MS 11'h7d0
`define TMR_OFF_MS 11'h000

`endif

// ===== hdl/sbc_ctrl_pkg.sv
// Types shared by the control register bank
package ctrl_bank_pkg;
  typedef enum logic [1:0] {pm_normal, pm_stop, pm_sleep,
                            pm_other} power_mode_e;
  typedef enum logic {tm_idle, tm_run} timer_state_e;
endpackage

// ===== sim/bus_wake_timer_control_regs_props.sv
// Port checks for the bus, wake and timer control registers
`timescale 1ns/1ps
module bus_wake_timer_control_regs_props
  import ctrl_bank_pkg::*;
#(
  parameter int TICK_CYCLES = 4
) (
  input wire clk_sys,
  input wire reset,
  input wire soft_reset,
  input wire restart,
  input power_mode_e power_mode,
  input wire reg_wr,
  input wire [6:0] reg_addr,
  input wire [7:0] reg_wr_data,
  input wire [7:0] reg_rd_data,
  input wire wake_pin,
  input wire [1:0] can_mode,
  input wire [1:0] lin_ch_a_mode,
  input wire [1:0] lin_ch_b_mode,
  input wire [1:0] lin_ch_c_mode,
  input wire lin_slope_control_enable,
  input wire lin_low_slope_select,
  input wire lin_tx_timeout_enable,
  input wire stop_watchdog_disable,
  input wire wake_pin_pull_up,
  input wire wake_pin_pull_down,
  input wire wake_pin_wake,
  input wire timer_wake
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ==========================================================
  // Sequences and helpers
  sequence s_wr_bus;
    reg_wr && reg_addr == 7'h04 && !soft_reset && !restart;
  endsequence
  sequence s_low_power;
    power_mode == pm_stop || power_mode == pm_sleep;
  endsequence
  function automatic logic [7:0] rsvd(input logic [6:0] a);
    case (a)
      7'h04: rsvd = 8'h04;
      7'h05: rsvd = 8'he4;
      7'h06: rsvd = 8'hbb;
      7'h07: rsvd = 8'hfe;
      7'h08: rsvd = 8'hfc;
      7'h0c: rsvd = 8'hf8;
      default: rsvd = 8'hff;
    endcase
  endfunction
  // ==========================================================
  // Properties
  property p_flash;
    s_wr_bus |-> ##2 lin_slope_control_enable == !$past(reg_wr_data[7], 2);
  endproperty
  property p_low;
    s_wr_bus |-> ##2 lin_low_slope_select == $past(reg_wr_data[6], 2);
  endproperty
  property p_txto;
    s_wr_bus |-> ##2 lin_tx_timeout_enable == $past(reg_wr_data[5], 2);
  endproperty
  property p_can_wake;
    s_low_power |=> can_mode != 2'h3;
  endproperty
  property p_lin_wake;
    s_low_power |=> lin_ch_a_mode != 2'h3 && lin_ch_b_mode != 2'h3
      && lin_ch_c_mode != 2'h3;
  endproperty
  property p_rsvd;
    1'b1 |=> (reg_rd_data & rsvd($past(reg_addr))) == 8'h00;
  endproperty
  property p_stop_wd;
    stop_watchdog_disable |-> $past(power_mode) == pm_stop;
  endproperty
  property p_tmr_pulse;
    timer_wake |=> !timer_wake [*8];
  endproperty
  property p_pin_src;
    wake_pin_wake |-> $past(wake_pin, 3) != $past(wake_pin, 4);
  endproperty
  property p_pull_excl;
    !(wake_pin_pull_up && wake_pin_pull_down);
  endproperty
  a_flash: assert property (p_flash)
    else $error("slope control does not follow flash bit");
  a_low: assert property (p_low)
    else $error("low slope output does not follow bit 6");
  a_txto: assert property (p_txto)
    else $error("timeout enable does not follow bit 5");
  a_can_wake: assert property (p_can_wake)
    else $error("CAN mode normal in low power");
  a_lin_wake: assert property (p_lin_wake)
    else $error("LIN mode normal in low power");
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bit read nonzero");
  a_stop_wd: assert property (p_stop_wd)
    else $error("watchdog disabled outside stop");
  a_tmr_pulse: assert property (p_tmr_pulse)
    else $error("timer wake pulses too close");
  a_pin_src: assert property (p_pin_src)
    else $error("wake pin pulse without pin edge");
  a_pull_excl: assert property (p_pull_excl)
    else $error("pull-up and pull-down both on");
endmodule

bind bus_wake_timer_control_regs bus_wake_timer_control_regs_props #(
  .TICK_CYCLES(TICK_CYCLES)
) u_props (
  .clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
  .restart(restart), .power_mode(power_mode), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .wake_pin(wake_pin), .can_mode(can_mode),
  .lin_ch_a_mode(lin_ch_a_mode), .lin_ch_b_mode(lin_ch_b_mode),
  .lin_ch_c_mode(lin_ch_c_mode),
  .lin_slope_control_enable(lin_slope_control_enable),
  .lin_low_slope_select(lin_low_slope_select),
  .lin_tx_timeout_enable(lin_tx_timeout_enable),
  .stop_watchdog_disable(stop_watchdog_disable),
  .wake_pin_pull_up(wake_pin_pull_up),
  .wake_pin_pull_down(wake_pin_pull_down),
  .wake_pin_wake(wake_pin_wake), .timer_wake(timer_wake)
);

// ===== sim/bus_wake_timer_control_regs_tb.sv
// Self-checking bench for the control register bank
`timescale 1ns/1ps
module bus_wake_timer_control_regs_tb
  import ctrl_bank_pkg::*;
;
  localparam int TICK = 4;
  logic clk_sys, reset, soft_reset, restart, reg_wr, wake_pin;
  power_mode_e power_mode;
  logic [6:0] reg_addr;
  logic [7:0] reg_wr_data, reg_rd_data;
  logic [1:0] can_mode, lin_ch_a_mode, lin_ch_b_mode, lin_ch_c_mode;
  logic lin_slope_control_enable, lin_low_slope_select;
  logic lin_tx_timeout_enable, stop_watchdog_disable;
  logic wake_pin_pull_up, wake_pin_pull_down, wake_pin_wake, timer_wake;
  int num_errors = 0;
  int checks = 0;
  int per_ms[7] = '{10, 20, 50, 100, 200, 1000, 2000};
  logic [6:0] adr[6] = '{7'h04, 7'h05, 7'h06, 7'h07, 7'h08, 7'h0c};
  logic [7:0] msk[6] = '{8'hfb, 8'h1b, 8'h44, 8'h01, 8'h03, 8'h07};

  bus_wake_timer_control_regs #(.TICK_CYCLES(TICK)) dut (
    .clk_sys(clk_sys), .reset(reset), .soft_reset(soft_reset),
    .restart(restart), .power_mode(power_mode), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .wake_pin(wake_pin), .can_mode(can_mode),
    .lin_ch_a_mode(lin_ch_a_mode), .lin_ch_b_mode(lin_ch_b_mode),
    .lin_ch_c_mode(lin_ch_c_mode),
    .lin_slope_control_enable(lin_slope_control_enable),
    .lin_low_slope_select(lin_low_slope_select),
    .lin_tx_timeout_enable(lin_tx_timeout_enable),
    .stop_watchdog_disable(stop_watchdog_disable),
    .wake_pin_pull_up(wake_pin_pull_up),
    .wake_pin_pull_down(wake_pin_pull_down),
    .wake_pin_wake(wake_pin_wake), .timer_wake(timer_wake)
  );

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // Shared tasks
  task automatic check(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    reg_wr = 1;
    reg_addr = a;
    reg_wr_data = d;
    step(1);
    reg_wr = 0;
    step(1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e, string nm);
    reg_addr = a;
    step(2);
    check(nm, reg_rd_data, e);
  endtask
  // Waits for a pulse; n ends above bound if none came
  task automatic wait_sig(input bit tmr, int bound, bit must, output int n);
    n = 0;
    do begin
      step(1);
      n++;
    end while ((tmr ? timer_wake : wake_pin_wake) !== 1'b1 && n <= bound);
    if (must && n > bound) begin
      num_errors++;
      conclude();
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_por();
    rd(7'h04, 8'h20, "bus_a");
    rd(7'h05, 8'h00, "bus_b");
    rd(7'h06, 8'h00, "wake_a");
    rd(7'h07, 8'h01, "wake_src");
    rd(7'h08, 8'h00, "pull");
    rd(7'h0c, 8'h00, "timer");
    rd(7'h09, 8'h00, "unmapped");
    check("slope_en", lin_slope_control_enable, 16'h1);
    check("txto", lin_tx_timeout_enable, 16'h1);
  endtask
  task automatic t_fields();
    logic [1:0] m;
    for (int i = 0; i < 6; i++) begin
      wr(adr[i], 8'hff);
      rd(adr[i], msk[i], "mask");
    end
    check("slope_off", lin_slope_control_enable, 16'h0);
    check("low", lin_low_slope_select, 16'h1);
    check("txto_on", lin_tx_timeout_enable, 16'h1);
    wr(7'h04, 8'h00);
    check("slope_on", lin_slope_control_enable, 16'h1);
    check("normal", lin_low_slope_select, 16'h0);
    check("txto_off", lin_tx_timeout_enable, 16'h0);
    for (int c = 0; c < 4; c++) begin
      m = c[1:0];
      wr(7'h04, {3'h0, m, 1'b0, m});
      wr(7'h05, {3'h0, m, 1'b0, m});
      step(1);
      check("can", can_mode, m);
      check("lin_a", lin_ch_a_mode, m);
      check("lin_b", lin_ch_b_mode, m);
      check("lin_c", lin_ch_c_mode, m);
    end
  endtask
  task automatic t_override();
    power_mode_e pms[2] = '{pm_stop, pm_sleep};
    for (int i = 0; i < 2; i++) begin
      if (i == 1) begin
        wr(7'h04, 8'h19);
      end
      power_mode = pms[i];
      step(2);
      check("can_lp", can_mode, 16'h1);
      check("lin_lp", {lin_ch_a_mode, lin_ch_b_mode, lin_ch_c_mode},
            16'h15);
      rd(7'h04, (i == 1) ? 8'h19 : 8'h1b, "kept");
      power_mode = pm_normal;
      step(2);
      check("can_back", can_mode, (i == 1) ? 16'h1 : 16'h3);
      check("lin_back", lin_ch_c_mode, 16'h3);
    end
    wr(7'h04, 8'h12);
    power_mode = pm_stop;
    step(2);
    check("rx_only", {lin_ch_a_mode, can_mode}, 16'ha);
    wr(7'h06, 8'h04);
    check("wd_off", stop_watchdog_disable, 16'h1);
    power_mode = pm_normal;
    step(2);
    check("wd_on", stop_watchdog_disable, 16'h0);
  endtask
  task automatic t_pull();
    for (int c = 0; c < 3; c++) begin
      wr(7'h08, c[7:0]);
      check("pull", {wake_pin_pull_up, wake_pin_pull_down},
            c[15:0]);
    end
    wake_pin = 1;
    wr(7'h08, 8'h03);
    step(3);
    check("auto_up", {wake_pin_pull_up, wake_pin_pull_down},
          16'h2);
    wake_pin = 0;
    step(5);
    check("auto_dn", {wake_pin_pull_up, wake_pin_pull_down},
          16'h1);
  endtask
  task automatic t_wake();
    int n;
    power_mode = pm_stop;
    wr(7'h07, 8'h01);
    wake_pin = 1;
    wait_sig(0, 8, 1, n);
    check("pin_wake", wake_pin_wake, 16'h1);
    wr(7'h07, 8'h00);
    wake_pin = 0;
    wait_sig(0, 8, 0, n);
    check("pin_masked", n > 8, 16'h1);
  endtask
  task automatic t_timer();
    int n;
    wr(7'h06, 8'h40);
    for (int i = 0; i < 7; i++) begin
      wr(7'h0c, i[7:0]);
      wait_sig(1, per_ms[i] * TICK + 8, 1, n);
      wait_sig(1, per_ms[i] * TICK + 8, 1, n);
      check("period", n, per_ms[i] * TICK);
    end
    wr(7'h0c, 8'h07);
    wait_sig(1, 100, 0, n);
    check("code7", n > 100, 16'h1);
    wr(7'h0c, 8'h00);
    wr(7'h06, 8'h00);
    wait_sig(1, 60, 0, n);
    check("tmr_off", n > 60, 16'h1);
    power_mode = pm_normal;
  endtask
  task automatic t_restart();
    wr(7'h06, 8'h44);
    wr(7'h08, 8'h02);
    wr(7'h0c, 8'h05);
    restart = 1;
    step(1);
    restart = 0;
    rd(7'h06, 8'h40, "rs_wake_a");
    rd(7'h08, 8'h02, "rs_pull");
    rd(7'h0c, 8'h05, "rs_timer");
    soft_reset = 1;
    step(1);
    soft_reset = 0;
    rd(7'h0c, 8'h00, "sr_timer");
    rd(7'h07, 8'h01, "sr_src");
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1;
    soft_reset = 0;
    restart = 0;
    reg_wr = 0;
    reg_addr = 7'h00;
    reg_wr_data = 8'h00;
    wake_pin = 0;
    power_mode = pm_normal;
    step(16);
    reset = 0;
    t_por();
    t_fields();
    wr(7'h04, 8'h1b);
    wr(7'h05, 8'h1b);
    t_override();
    t_pull();
    t_wake();
    power_mode = pm_stop;
    t_timer();
    t_restart();
    conclude();
  end
endmodule
